// >>> ooes_params.svh
// Purpose: constants of the output offset and expand scaler
// Assumes: byte addresses on a 32-bit register port, 125 MHz core clock
// Notes: signal full scale is code 16384; offsets are in hundredths of a percent
`ifndef OOES_PARAMS_SVH
`define OOES_PARAMS_SVH
`define OOES_CLK_HZ 125000000
`define OOES_FAST_HZ 256000
`define OOES_FAST_CYC (`OOES_CLK_HZ / `OOES_FAST_HZ)
`define OOES_SLOW_HZ 512
`define OOES_SLOW_CYC (`OOES_CLK_HZ / `OOES_SLOW_HZ)
`define OOES_FULL_SCALE 18'sh04000
`define OOES_OFF_MAX 16'sh2904
`define OOES_OFF_UNITY 16'sh2710
`define OOES_OFF_TO_CODE 12'h68e
`define OOES_EXP_MIN 9'h001
`define OOES_EXP_MAX 9'h100
`define OOES_SRC_LAST 3'h6
`define OOES_ADDR_SRC 8'h00
`define OOES_ADDR_OFF_X 8'h04
`define OOES_ADDR_OFF_Y 8'h08
`define OOES_ADDR_OFF_R 8'h0c
`define OOES_ADDR_EXP_X 8'h10
`define OOES_ADDR_EXP_Y 8'h14
`define OOES_ADDR_EXP_R 8'h18
`define OOES_ADDR_AUTO 8'h1c
`define OOES_ADDR_DISP 8'h20
`define OOES_ADDR_STAT 8'h24
`define OOES_ADDR_MASK 8'h28
`define OOES_ADDR_GAIN 8'h2c
`define OOES_ADDR_LIVE 8'h30
`define OOES_STAT_OVL 0
`define OOES_STAT_REJ 1
`define OOES_RST_OFF 16'h0000
`define OOES_RST_EXP 9'h001
`endif

// >>> ooes_pkg.sv
// Purpose: types of the output offset and expand scaler
// Assumes: constants come from ooes_params.svh
// Notes: the whole block state is one packed struct
package ooes_pkg;
   typedef enum logic [2:0]
   {
      OOES_SRC_PRIMARY = 3'h0,
      OOES_SRC_MAG = 3'h1,
      OOES_SRC_PHASE = 3'h2,
      OOES_SRC_TRACE1 = 3'h3,
      OOES_SRC_TRACE2 = 3'h4,
      OOES_SRC_TRACE3 = 3'h5,
      OOES_SRC_TRACE4 = 3'h6
   } ooes_src_t;

   typedef struct packed
   {
      logic [2:0] ch1_src;
      logic [2:0] ch2_src;
      logic [2:0][15:0] offset;
      logic [2:0][8:0] expand;
      logic [1:0][2:0] disp_dep;
      logic [7:0] reserve_db;
      logic [7:0] max_gain_db;
      logic [1:0] status;
      logic [1:0] mask;
      logic [8:0] fast_cnt;
      logic [17:0] slow_cnt;
      logic [15:0] ch1;
      logic [15:0] ch2;
      logic [1:0] ovl_ch;
      logic ovl;
      logic irq;
      logic [31:0] rdata;
      logic [1:0] off_ind;
      logic [1:0] exp_ind;
      logic [2:0][15:0] trace_val;
   } ooes_state_t;
endpackage : ooes_pkg

// >>> ooes_scaler.sv
// Purpose: offset, expand and clamp of X, Y and magnitude onto two output channels
// Assumes: all inputs come from logic on core_clk_in; full scale signal is code 16384
// Notes: channel codes are DAC words, +/-16384 is +/-10 V
`timescale 1ns/1ps
`include "ooes_params.svh"

// Notes on behaviour
// [RULE1] A channel sourcing X or Y is refreshed on a 256 kHz tick.
// [RULE2] A channel sourcing magnitude, phase or a trace is refreshed on a 512 Hz tick only.
// [RULE3] Channel one offers X, magnitude, phase and four traces, never Y.
// [RULE4] Channel two offers Y, magnitude, phase and four traces, never X.
// [RULE5] Output is (signal minus offset fraction) times expand, scaled to 10 V full scale.
// [RULE6] Expand takes 1 to 256 and the expanded output never passes full scale.
// [RULE7] Offsets span -105.00% to 105.00% and do not follow sensitivity.
// [RULE8] Auto offset loads the offset that zeroes the chosen quantity.
// [RULE9] Offsets never feed magnitude or phase, which use raw X and Y.
// [RULE10] Trace values of X, Y and magnitude carry the current offset.
// [RULE11] Trace values are not multiplied by the expand factor.
// [RULE12] An expanded output that would pass full scale raises the overload flag. The code raises it only for an output shown on channel one or two.
// [RULE13] Each display shows offset and expand indicators for the quantities it uses.
// [RULE14] Only X, Y and magnitude own an offset and an expand setting.
// [RULE15] Expand whose gain plus reserve passes the allowed DC gain is refused.
// [RULE16] An expand change never alters the time constant.
// [RULE17] Clamping is symmetric at plus and minus full scale.
module ooes_scaler
   import ooes_pkg::*;
#(
   parameter logic [17:0] SLOW_CYC = 18'(`OOES_SLOW_CYC)
)
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire logic signed [15:0] x_in,
   input wire logic signed [15:0] y_in,
   input wire logic signed [15:0] mag_in,
   input wire logic signed [15:0] phase_in,
   input wire logic signed [15:0] trace1_in,
   input wire logic signed [15:0] trace2_in,
   input wire logic signed [15:0] trace3_in,
   input wire logic signed [15:0] trace4_in,
   output logic [15:0] output_channel_one_out,
   output logic [15:0] output_channel_two_out,
   output logic output_overload_flag_out,
   output logic [15:0] x_trace_out,
   output logic [15:0] y_trace_out,
   output logic [15:0] mag_trace_out,
   output logic [1:0] offset_ind_out,
   output logic [1:0] expand_ind_out,
   output logic irq_out
);
   localparam logic [8:0] FAST_CYC = 9'(`OOES_FAST_CYC);

   ooes_state_t cur;
   ooes_state_t nxt;
   logic signed [15:0] sig [3];
   logic signed [15:0] trace_in [4];
   logic signed [15:0] outv [3];
   logic [2:0] clip;
   logic [15:0] trv [3];
   logic [2:0] off_nz;
   logic [2:0] exp_big;
   logic fast_tick;
   logic slow_tick;

   assign sig[0] = x_in;
   assign sig[1] = y_in;
   assign sig[2] = mag_in;
   assign trace_in[0] = trace1_in;
   assign trace_in[1] = trace2_in;
   assign trace_in[2] = trace3_in;
   assign trace_in[3] = trace4_in;
   assign fast_tick = (cur.fast_cnt == 9'h000);
   assign slow_tick = (cur.slow_cnt == 18'h00000);

   // conservative expand gain in dB: 6 dB per started octave
   function automatic logic [7:0] exp_db(input logic [8:0] e);
      logic [7:0] db;
      db = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         if (e > (9'h001 << i))
         begin
            db = 8'(6 * (i + 1));
         end
      end
      return db;
   endfunction : exp_db

   // per quantity datapath; magnitude arrives unoffset from upstream
   // [RULE9] raw inputs only
   for (genvar q = 0; q < 3; q++)
   begin : g_qty
      logic signed [27:0] off_code;
      logic signed [17:0] diff;
      logic signed [27:0] prod;
      // [RULE5] offset then expand
      assign off_code = $signed(cur.offset[q]) * $signed({1'b0, `OOES_OFF_TO_CODE});
      assign diff = 18'(sig[q]) - 18'(off_code >>> 10);
      assign prod = 28'(diff) * $signed({1'b0, cur.expand[q]});
      // [RULE17] symmetric clamp
      assign clip[q] = (prod > 28'(`OOES_FULL_SCALE)) || (prod < -28'(`OOES_FULL_SCALE));
      assign outv[q] = (prod > 28'(`OOES_FULL_SCALE)) ? 16'(`OOES_FULL_SCALE) :
                       (prod < -28'(`OOES_FULL_SCALE)) ? -16'(`OOES_FULL_SCALE) :
                       16'(prod);
      // [RULE10] traces carry offset, [RULE11] but no expand
      assign trv[q] = (diff > 18'sh07fff) ? 16'h7fff :
                      (diff < -18'sh07fff) ? 16'h8001 : 16'(diff);
      assign off_nz[q] = (cur.offset[q] != 16'h0000);
      assign exp_big[q] = (cur.expand[q] != 9'h001);
   end

   always_comb
   begin
      logic [1:0] qsel;
      logic signed [29:0] auto_val;
      logic signed [15:0] woff;
      logic [8:0] wexp;
      logic reject;
      logic ovl_evt;
      logic [1:0] w1c;
      qsel = 2'h0;
      auto_val = 30'h00000000;
      woff = wdata_in[15:0];
      wexp = wdata_in[8:0];
      reject = 1'b0;
      ovl_evt = 1'b0;
      w1c = 2'h0;
      nxt = cur;
      nxt.fast_cnt = fast_tick ? FAST_CYC - 9'h001 : cur.fast_cnt - 9'h001;
      nxt.slow_cnt = slow_tick ? SLOW_CYC - 18'h00001 : cur.slow_cnt - 18'h00001;

      // [RULE1] X on channel one at the fast rate
      if (fast_tick && cur.ch1_src == OOES_SRC_PRIMARY)
      begin
         nxt.ch1 = outv[0];
         nxt.ovl_ch[0] = clip[0];
      end
      // [RULE2] slow sources on channel one
      else if (slow_tick && cur.ch1_src != OOES_SRC_PRIMARY)
      begin
         nxt.ch1 = (cur.ch1_src == OOES_SRC_MAG) ? outv[2] :
                   (cur.ch1_src == OOES_SRC_PHASE) ? phase_in :
                   trace_in[2'(cur.ch1_src - OOES_SRC_TRACE1)];
         nxt.ovl_ch[0] = (cur.ch1_src == OOES_SRC_MAG) && clip[2];
      end
      // [RULE1] Y on channel two at the fast rate
      if (fast_tick && cur.ch2_src == OOES_SRC_PRIMARY)
      begin
         nxt.ch2 = outv[1];
         nxt.ovl_ch[1] = clip[1];
      end
      // [RULE2] slow sources on channel two
      else if (slow_tick && cur.ch2_src != OOES_SRC_PRIMARY)
      begin
         nxt.ch2 = (cur.ch2_src == OOES_SRC_MAG) ? outv[2] :
                   (cur.ch2_src == OOES_SRC_PHASE) ? phase_in :
                   trace_in[2'(cur.ch2_src - OOES_SRC_TRACE1)];
         nxt.ovl_ch[1] = (cur.ch2_src == OOES_SRC_MAG) && clip[2];
      end
      // [RULE12] overload while a shown output clips
      nxt.ovl = |nxt.ovl_ch;
      ovl_evt = nxt.ovl;

      for (int q = 0; q < 3; q++)
      begin
         nxt.trace_val[q] = trv[q];
      end
      // [RULE13] per display indicators
      for (int d = 0; d < 2; d++)
      begin
         nxt.off_ind[d] = |(cur.disp_dep[d] & off_nz);
         nxt.exp_ind[d] = |(cur.disp_dep[d] & exp_big);
      end

      if (wr_in)
      begin
         unique case (addr_in)
            `OOES_ADDR_SRC:
            begin
               // [RULE3] [RULE4] code 0 is X on one and Y on two only
               if (wdata_in[2:0] > `OOES_SRC_LAST || wdata_in[5:3] > `OOES_SRC_LAST)
               begin
                  reject = 1'b1;
               end
               else
               begin
                  nxt.ch1_src = wdata_in[2:0];
                  nxt.ch2_src = wdata_in[5:3];
               end
            end
            // [RULE14] offsets only for X, Y, magnitude
            `OOES_ADDR_OFF_X, `OOES_ADDR_OFF_Y, `OOES_ADDR_OFF_R:
            begin
               qsel = 2'(addr_in[3:2] - 2'h1);
               // [RULE7] range check, no tie to sensitivity
               if (woff > $signed(`OOES_OFF_MAX) || woff < -$signed(`OOES_OFF_MAX))
               begin
                  reject = 1'b1;
               end
               else
               begin
                  nxt.offset[qsel] = woff;
               end
            end
            `OOES_ADDR_EXP_X, `OOES_ADDR_EXP_Y, `OOES_ADDR_EXP_R:
            begin
               qsel = 2'(addr_in[3:2]);
               qsel = (addr_in == `OOES_ADDR_EXP_R) ? 2'h2 : qsel;
               // [RULE6] [RULE15] range and DC gain budget; [RULE16] no time constant output
               if (wexp < `OOES_EXP_MIN || wexp > `OOES_EXP_MAX ||
                   ({1'b0, cur.reserve_db} + {1'b0, exp_db(wexp)}) > {1'b0, cur.max_gain_db})
               begin
                  reject = 1'b1;
               end
               else
               begin
                  nxt.expand[qsel] = wexp;
               end
            end
            `OOES_ADDR_AUTO:
            begin
               // [RULE8] offset that zeroes the quantity
               if (wdata_in[1:0] == 2'h3)
               begin
                  reject = 1'b1;
               end
               else
               begin
                  qsel = wdata_in[1:0];
                  auto_val = 30'(sig[qsel] * $signed({1'b0, `OOES_OFF_UNITY})) >>> 14;
                  nxt.offset[qsel] = (auto_val > 30'(`OOES_OFF_MAX)) ? `OOES_OFF_MAX :
                                     (auto_val < -30'(`OOES_OFF_MAX)) ? -`OOES_OFF_MAX :
                                     16'(auto_val);
               end
            end
            `OOES_ADDR_DISP:
            begin
               nxt.disp_dep = wdata_in[5:0];
            end
            `OOES_ADDR_STAT:
            begin
               w1c = wdata_in[1:0];
            end
            `OOES_ADDR_MASK:
            begin
               nxt.mask = wdata_in[1:0];
            end
            `OOES_ADDR_GAIN:
            begin
               nxt.reserve_db = wdata_in[7:0];
               nxt.max_gain_db = wdata_in[15:8];
            end
            default:
            begin
               reject = 1'b0;
            end
         endcase
      end

      // set wins over a same-cycle clear
      nxt.status = (cur.status & ~w1c) | {reject, ovl_evt};
      nxt.irq = |(nxt.status & nxt.mask);

      nxt.rdata = 32'h00000000;
      if (rd_in)
      begin
         unique case (addr_in)
            `OOES_ADDR_SRC: nxt.rdata = {26'h0, cur.ch2_src, cur.ch1_src};
            `OOES_ADDR_OFF_X: nxt.rdata = {{16{cur.offset[0][15]}}, cur.offset[0]};
            `OOES_ADDR_OFF_Y: nxt.rdata = {{16{cur.offset[1][15]}}, cur.offset[1]};
            `OOES_ADDR_OFF_R: nxt.rdata = {{16{cur.offset[2][15]}}, cur.offset[2]};
            `OOES_ADDR_EXP_X: nxt.rdata = {23'h0, cur.expand[0]};
            `OOES_ADDR_EXP_Y: nxt.rdata = {23'h0, cur.expand[1]};
            `OOES_ADDR_EXP_R: nxt.rdata = {23'h0, cur.expand[2]};
            `OOES_ADDR_DISP: nxt.rdata = {26'h0, cur.disp_dep};
            `OOES_ADDR_STAT: nxt.rdata = {30'h0, cur.status};
            `OOES_ADDR_MASK: nxt.rdata = {30'h0, cur.mask};
            `OOES_ADDR_GAIN: nxt.rdata = {16'h0, cur.max_gain_db, cur.reserve_db};
            `OOES_ADDR_LIVE: nxt.rdata = {29'h0, cur.ovl_ch, cur.ovl};
            default: nxt.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cur <= '0;
         cur.ch2_src <= OOES_SRC_PRIMARY;
         cur.expand <= {3{`OOES_RST_EXP}};
         cur.offset <= {3{`OOES_RST_OFF}};
         cur.max_gain_db <= 8'hff;
      end
      else
      begin
         cur <= nxt;
      end
   end

   assign rdata_out = cur.rdata;
   assign output_channel_one_out = cur.ch1;
   assign output_channel_two_out = cur.ch2;
   assign output_overload_flag_out = cur.ovl;
   assign x_trace_out = cur.trace_val[0];
   assign y_trace_out = cur.trace_val[1];
   assign mag_trace_out = cur.trace_val[2];
   assign offset_ind_out = cur.off_ind;
   assign expand_ind_out = cur.exp_ind;
   assign irq_out = cur.irq;

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   a_fast_update_time: assert property ( // [RULE1]
      $changed(cur.ch1) && cur.ch1_src == OOES_SRC_PRIMARY && $stable(cur.ch1_src)
      |-> $past(fast_tick))
      else $error("fast channel changed off tick");
   a_slow_update_time: assert property ( // [RULE2]
      $changed(cur.ch2) && cur.ch2_src != OOES_SRC_PRIMARY && $stable(cur.ch2_src)
      |-> $past(slow_tick))
      else $error("slow channel changed off tick");
   a_source_legal: assert property ( // [RULE3]
      cur.ch1_src <= `OOES_SRC_LAST && cur.ch2_src <= `OOES_SRC_LAST)
      else $error("illegal source code");
   a_clamp_limit: assert property ( // [RULE17]
      cur.ch1_src == OOES_SRC_PRIMARY |-> $signed(cur.ch1) <= 16'(`OOES_FULL_SCALE)
      && $signed(cur.ch1) >= -16'(`OOES_FULL_SCALE))
      else $error("channel one beyond full scale");
   a_offset_range: assert property ( // [RULE7]
      $signed(cur.offset[0]) <= $signed(`OOES_OFF_MAX)
      && $signed(cur.offset[0]) >= -$signed(`OOES_OFF_MAX))
      else $error("offset outside range");
   a_expand_range: assert property ( // [RULE6]
      cur.expand[2] >= `OOES_EXP_MIN && cur.expand[2] <= `OOES_EXP_MAX)
      else $error("expand outside range");
   a_expand_refused: assert property ( // [RULE6]
      wr_in && addr_in == `OOES_ADDR_EXP_X && wdata_in[8:0] == 9'h000
      |=> $stable(cur.expand[0]) && cur.status[`OOES_STAT_REJ])
      else $error("bad expand accepted");
   a_overload_follow: assert property ( // [RULE12]
      output_overload_flag_out == |cur.ovl_ch)
      else $error("overload flag mismatch");
   a_irq_level: assert property (
      irq_out == |(cur.status & cur.mask))
      else $error("interrupt level mismatch");
endmodule : ooes_scaler

// >>> ooes_dac_model.sv
// Purpose: behavioural model of the two output DACs behind the channel connectors
// Assumes: codes arrive registered on core_clk_in, +/-16384 is +/-10 V
// Notes: reports millivolts and counts channel one code changes so the bench can judge update rates
`timescale 1ns/1ps
module ooes_dac_model
#(
   parameter int FULL_CODE = 16384,
   parameter int FULL_MV = 10000
)
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [15:0] code_one_in,
   input wire logic [15:0] code_two_in,
   output int mv_one_out,
   output int mv_two_out,
   output int upd_one_out
);
   logic [15:0] last_one;

   assign mv_one_out = $signed(code_one_in) * FULL_MV / FULL_CODE;
   assign mv_two_out = $signed(code_two_in) * FULL_MV / FULL_CODE;

   // a change of code is one conversion seen at the connector
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         last_one <= 16'h0000;
         upd_one_out <= 0;
      end
      else if (code_one_in !== last_one)
      begin
         last_one <= code_one_in;
         upd_one_out <= upd_one_out + 1;
      end
   end
endmodule : ooes_dac_model

// >>> tb_top.sv
// Purpose: self-checking bench of the output offset and expand scaler
// Assumes: slow tick shortened to 1000 cycles, so it is slower than the 488 cycle fast tick
// Notes: register port driven right after rising edges, read data sampled 1 ns later
`timescale 1ns/1ps
`include "ooes_params.svh"
module tb_top
   import ooes_pkg::*;
;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic [31:0] rdata_out;
   logic signed [15:0] x_in = 16'sh0, y_in = 16'sh0, mag_in = 16'sh0, phase_in = 16'sh0;
   logic signed [15:0] tr_in [4] = '{16'sh0, 16'sh0, 16'sh0, 16'sh0};
   logic [15:0] ch1, ch2, xt, yt, mt;
   logic ovl, irq;
   logic [1:0] off_ind, exp_ind;
   int mv1, mv2, upd1, err_total, n_checks, u0;
   logic [31:0] rd;
   logic [7:0] t_a [10] = '{8'h04, 8'h04, 8'h10, 8'h10, 8'h10, 8'h00, 8'h00, 8'h10,
      8'h2c, 8'h10};
   logic [31:0] t_d [10] = '{32'd10501, 32'hffffd6fc, 32'h0, 32'd257, 32'd256, 32'h7,
      32'h38, 32'h1, 32'h4140, 32'h2};
   logic t_r [10] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

   ooes_scaler #(.SLOW_CYC(18'd1000)) DUT (.core_clk_in(core_clk_in), .rst_in(rst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .x_in(x_in), .y_in(y_in), .mag_in(mag_in),
      .phase_in(phase_in), .trace1_in(tr_in[0]), .trace2_in(tr_in[1]),
      .trace3_in(tr_in[2]), .trace4_in(tr_in[3]), .output_channel_one_out(ch1),
      .output_channel_two_out(ch2), .output_overload_flag_out(ovl), .x_trace_out(xt),
      .y_trace_out(yt), .mag_trace_out(mt), .offset_ind_out(off_ind),
      .expand_ind_out(exp_ind), .irq_out(irq));

   ooes_dac_model dac (.core_clk_in(core_clk_in), .rst_in(rst_in), .code_one_in(ch1),
      .code_two_in(ch2), .mv_one_out(mv1), .mv_two_out(mv2), .upd_one_out(upd1));

   initial
   begin
      forever #4 core_clk_in = ~core_clk_in;
   end

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_flag(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask : chk_flag

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask : rd_reg

   // bounded wait for a channel code; the slow tick needs up to 1000 cycles
   task automatic wait_ch(input logic sel, input logic [15:0] exp);
      for (int i = 0; i < 1200; i++)
      begin
         @(posedge core_clk_in);
         #1;
         if ((sel ? ch2 : ch1) === exp)
            break;
      end
      chk_word({16'h0, sel ? ch2 : ch1}, {16'h0, exp});
   endtask : wait_ch

   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report

   // long enough for roughly a hundred slow ticks plus the bus traffic
   initial
   begin
      #(100000 * 8);
      err_total++;
      final_report();
   end

   initial
   begin
      repeat (3) @(posedge core_clk_in);
      rst_in <= 1'b0;
      rd_reg(8'h10, rd); chk_word(rd, 32'h1);
      rd_reg(8'h04, rd); chk_word(rd, 32'h0);
      rd_reg(8'h3c, rd); chk_word(rd, 32'h0);
      @(posedge core_clk_in);
      x_in <= 16'sd8192;
      wr_reg(8'h10, 32'h4);
      rd_reg(8'h10, rd); chk_word(rd, 32'h4);
      wait_ch(1'b0, 16'h4000);
      chk_flag(ovl, 1'b1);
      chk_word(32'(mv1), 32'd10000);
      @(posedge core_clk_in);
      x_in <= -16'sd8192;
      wait_ch(1'b0, 16'hc000);
      chk_flag(ovl, 1'b1);
      @(posedge core_clk_in);
      x_in <= 16'sd4096;
      wr_reg(8'h10, 32'h1);
      wait_ch(1'b0, 16'h1000);
      chk_flag(ovl, 1'b0);
      wr_reg(8'h1c, 32'h0);
      rd_reg(8'h04, rd); chk_word(rd, 32'd2500);
      wr_reg(8'h04, 32'd5000);
      wr_reg(8'h20, 32'h1);
      mag_in <= 16'sd3000;
      x_in <= 16'sd8192;
      // 5000 hundredths of a percent is code 5000*1678>>>10 = 8193
      wait_ch(1'b0, 16'hffff);
      chk_word({16'h0, xt}, 32'h0000ffff);
      chk_word({16'h0, mt}, 32'd3000);
      chk_word({30'h0, off_ind}, 32'h1);
      wr_reg(8'h10, 32'h2);
      wait_ch(1'b0, 16'hfffe);
      chk_word({16'h0, xt}, 32'h0000ffff);
      chk_word({30'h0, exp_ind}, 32'h1);
      wr_reg(8'h04, 32'h0);
      wr_reg(8'h10, 32'h1);
      wr_reg(8'h28, 32'h2);
      for (int i = 0; i < 10; i++)
      begin
         wr_reg(8'h24, 32'h3);
         wr_reg(t_a[i], t_d[i]);
         rd_reg(8'h24, rd);
         chk_flag(rd[1], t_r[i]);
      end
      chk_flag(irq, 1'b1);
      rd_reg(8'h10, rd); chk_word(rd, 32'h1);
      rd_reg(8'h04, rd); chk_word(rd, 32'hffffd6fc);
      wr_reg(8'h24, 32'h3);
      repeat (2) @(posedge core_clk_in);
      #1 chk_flag(irq, 1'b0);
      wr_reg(8'h2c, 32'hff00);
      wr_reg(8'h04, 32'h0);
      for (int s = 0; s < 2; s++)
      begin
         wr_reg(8'h00, s ? 32'h2 : 32'h0);
         u0 = upd1;
         repeat (2000)
         begin
            @(posedge core_clk_in);
            x_in <= x_in + 16'sd1;
            phase_in <= phase_in + 16'sd1;
         end
         // about four fast ticks against two slow ones in the same span
         chk_flag(s ? (upd1 - u0 <= 3) : (upd1 - u0 >= 4), 1'b1);
      end
      for (int k = 0; k < 4; k++)
      begin
         @(posedge core_clk_in);
         tr_in[k] <= 16'sd700 + 16'(k);
         wr_reg(8'h00, 32'(k + 3));
         wait_ch(1'b0, 16'd700 + 16'(k));
      end
      @(posedge core_clk_in);
      y_in <= 16'sd1000;
      wr_reg(8'h00, 32'h0);
      wait_ch(1'b1, 16'd1000);
      wr_reg(8'h00, 32'h8);
      wait_ch(1'b1, 16'd3000);
      chk_word(32'(mv2), 32'd1831);
      final_report();
   end
endmodule : tb_top
